// ==== uartrg_top.v ====
`timescale 1ns/1ps
`include "uartrg_consts.vh"
module uartrg_top (
    // Clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    input wire ce_i,
    // Processor bus
    input wire chip_select_n_i,
    input wire reg_select_hi_i,
    input wire reg_select_lo_i,
    input wire wr_n_i,
    input wire rd_n_i,
    input wire [7:0] data_i,
    output reg [7:0] data_o,
    output reg data_oe_n_o,
    // Serial and modem pins
    input wire serial_in_i,
    output reg serial_out_o,
    input wire cts_n_i,
    input wire dsr_n_i,
    output reg rts_n_o,
    output reg dtr_n_o,
    // Status pins
    output reg tx_holding_empty_o,
    output reg rx_ready_o,
    output reg irq_out_o,
    output reg clock_out_pin_o
);
    reg [7:0] line_config_r;
    reg [7:0] rate_select_r;
    reg [7:0] modem_control_r;
    reg [7:0] line_status_r;
    reg [7:0] rx_holding_r;
    reg [7:0] tx_holding_r;
    reg [1:0] sin_s_r, cts_s_r, dsr_s_r;
    reg cts_d_r, dsr_d_r, tc_d_r, ms_d_r;
    reg wr_d_r, rd_d_r, clk_div_r;
    wire tick;
    wire clk16;
    wire rx_done;
    wire [7:0] rx_data;
    wire rx_par_bit, rx_perr, rx_ferr, rx_brk;
    wire [1:0] sel = {reg_select_hi_i, reg_select_lo_i};
    wire sel_ok = !chip_select_n_i;
    // Strobes are sampled on this clock; writes act at the leading edge, read side effects at the trailing edge
    wire wr_end = sel_ok && !wr_n_i && !wr_d_r;
    wire rd_act = sel_ok && !rd_n_i;
    wire rd_end = rd_d_r && rd_n_i;
    wire [1:0] mode = modem_control_r[`URG_MC_MODE_LO +: 2];
    wire cts = cts_s_r[1];
    reg serial_out_int;
    wire rx_line = (mode == `URG_MODE_LOOP) ? serial_out_int : sin_s_r[1];
    reg [3:0] tph_r;
    reg [3:0] tbit_r;
    reg tbusy_r;
    reg [10:0] tsh_r;
    reg [3:0] tlen_r;
    reg rd_ls_r;
    reg [1:0] rd_sel_r;
    // A holding read that ends with a new character frees the slot, so no overrun
    wire rbr_free = !rx_ready_o || (rd_end && rd_sel_r == `URG_SEL_DATA);
    uartrg_rate_gen u_rate (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .pre_sel_i(rate_select_r[`URG_RS_PRE_LO +: 2]),
        .div_sel_i(rate_select_r[`URG_RS_DIV_LO +: 5]),
        .tick_o(tick),
        .clk16_o(clk16)
    );
    uartrg_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .en_i(modem_control_r[`URG_MC_RX_EN]),
        .len_i(line_config_r[`URG_LC_LEN_LO +: 2]),
        .two_stop_i(line_config_r[`URG_LC_STOP]),
        .par_i(line_config_r[`URG_LC_RXPAR_LO +: 2]),
        .line_i(rx_line),
        .done_o(rx_done),
        .data_o(rx_data),
        .par_bit_o(rx_par_bit),
        .par_err_o(rx_perr),
        .frm_err_o(rx_ferr),
        .brk_o(rx_brk)
    );
    // Build a transmit frame: start, data LSB first, parity, stop
    function [10:0] frame;
        input [7:0] d;
        input [1:0] len;
        input pen;
        input pbit;
        reg [3:0] n;
        begin
            n = {2'h0, len} + 4'h5;
            frame = 11'h7FF;
            frame[8:1] = d | (8'hFF << n);
            if (pen) begin
                frame[n + 4'h1] = pbit;
            end
            frame[0] = 1'b0;
        end
    endfunction
    wire [3:0] tx_n = {2'h0, line_config_r[`URG_LC_LEN_LO +: 2]} + 4'h5;
    wire tx_pen = line_config_r[`URG_LC_TXPAR_EN];
    wire [3:0] tx_bits = tx_n + 4'h2 + {3'h0, tx_pen} + {3'h0, line_config_r[`URG_LC_STOP]};
    wire tx_pbit = ^(tx_holding_r & ~(8'hFF << tx_n)) ^ line_config_r[`URG_LC_RXPAR_LO];
    wire echo = (mode == `URG_MODE_ECHO);
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sin_s_r <= 2'h3;
            cts_s_r <= 2'h0;
            dsr_s_r <= 2'h0;
            cts_d_r <= 1'b0;
            dsr_d_r <= 1'b0;
            tc_d_r <= 1'b1;
            ms_d_r <= 1'b0;
            wr_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            rd_ls_r <= 1'b0;
            rd_sel_r <= 2'h0;
            clk_div_r <= 1'b0;
            line_config_r <= 8'h00;
            rate_select_r <= 8'h00;
            modem_control_r <= 8'h00;
            line_status_r <= `URG_LS_RESET;
            rx_holding_r <= 8'h00;
            tx_holding_r <= 8'h00;
            tph_r <= 4'h0;
            tbit_r <= 4'h0;
            tbusy_r <= 1'b0;
            tsh_r <= 11'h7FF;
            tlen_r <= 4'h0;
            serial_out_int <= 1'b1;
            serial_out_o <= 1'b1;
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
            rts_n_o <= 1'b1;
            dtr_n_o <= 1'b1;
            tx_holding_empty_o <= 1'b1;
            rx_ready_o <= 1'b0;
            irq_out_o <= 1'b0;
            clock_out_pin_o <= 1'b0;
        end else if (ce_i) begin
            sin_s_r <= {sin_s_r[0], serial_in_i};
            cts_s_r <= {cts_s_r[0], !cts_n_i};
            dsr_s_r <= {dsr_s_r[0], !dsr_n_i};
            cts_d_r <= cts_s_r[1];
            dsr_d_r <= dsr_s_r[1];
            wr_d_r <= sel_ok && !wr_n_i;
            rd_d_r <= rd_act;
            if (rd_act) begin
                rd_sel_r <= sel;
                rd_ls_r <= (sel == `URG_SEL_LINE);
            end
            clk_div_r <= !clk_div_r;
            // Register writes
            if (wr_end) begin
                case (sel)
                    `URG_SEL_DATA: begin
                        tx_holding_r <= data_i;
                        line_status_r[`URG_LS_THE] <= 1'b0;
                    end
                    `URG_SEL_LINE: line_config_r <= {2'h0, data_i[5:0]};
                    `URG_SEL_MODEM: modem_control_r <= {1'b0, data_i[6:0]};
                    `URG_SEL_RATE: rate_select_r <= data_i;
                    default: rate_select_r <= rate_select_r;
                endcase
            end
            // Read data
            data_oe_n_o <= !rd_act;
            case (sel)
                `URG_SEL_DATA: data_o <= rx_holding_r;
                `URG_SEL_LINE: data_o <= line_status_r;
                `URG_SEL_MODEM: data_o <= modem_control_r;
                `URG_SEL_RATE: data_o <= {6'h00, dsr_s_r[1], cts_s_r[1]};
                default: data_o <= 8'h00;
            endcase
            // Status read clears at strobe end; a bit set in that same cycle stays set
            if (rd_end && rd_ls_r) begin
                line_status_r <= 8'h00;
                tc_d_r <= 1'b0;
                ms_d_r <= 1'b0;
            end
            if (rd_end && rd_sel_r == `URG_SEL_DATA) begin
                line_status_r[`URG_LS_RDY] <= 1'b0;
                rx_ready_o <= 1'b0;
            end
            if ((cts_s_r[1] ^ cts_d_r) || (dsr_s_r[1] ^ dsr_d_r)) begin
                line_status_r[`URG_LS_MS] <= 1'b1;
            end
            if (rx_done) begin
                line_status_r[`URG_LS_OVR] <= !rbr_free;
                line_status_r[`URG_LS_FRM] <= rx_ferr;
                line_status_r[`URG_LS_PAR] <= rx_perr;
                line_status_r[`URG_LS_BRK] <= rx_brk;
                if (rbr_free) begin
                    rx_holding_r <= rx_data;
                    line_status_r[`URG_LS_RDY] <= 1'b1;
                    rx_ready_o <= 1'b1;
                end
            end
            // Transmitter
            if (tick && tbusy_r) begin
                tph_r <= tph_r + 4'h1;
                if (tph_r == 4'hF) begin
                    tsh_r <= {1'b1, tsh_r[10:1]};
                    tbit_r <= tbit_r + 4'h1;
                    if (tbit_r == tlen_r - 4'h1) begin
                        tbusy_r <= 1'b0; // character always completes
                    end
                end
            end else if (!tbusy_r && echo && rx_done) begin
                // Echo ignores programmed transmit parity
                tsh_r <= frame(rx_data, line_config_r[1:0],
                    line_config_r[`URG_LC_RXPAR_LO +: 2] != `URG_PAR_NONE, rx_par_bit);
                tlen_r <= tx_n + 4'h2 + {3'h0, line_config_r[`URG_LC_RXPAR_LO +: 2] != 2'h0};
                tbusy_r <= 1'b1;
                tph_r <= 4'h0;
                tbit_r <= 4'h0;
            end else if (!tbusy_r && !tx_holding_empty_o && !wr_end &&
                         (cts || mode == `URG_MODE_LOOP)) begin
                tsh_r <= (mode == `URG_MODE_BREAK) ? 11'h000 :
                    frame(tx_holding_r, line_config_r[1:0], tx_pen, tx_pbit);
                tlen_r <= tx_bits;
                tbusy_r <= 1'b1;
                tph_r <= 4'h0;
                tbit_r <= 4'h0;
                tx_holding_empty_o <= 1'b1;
                line_status_r[`URG_LS_THE] <= 1'b1;
            end
            if (wr_end && sel == `URG_SEL_DATA) begin
                tx_holding_empty_o <= 1'b0;
            end
            serial_out_int <= tbusy_r ? tsh_r[0] : 1'b1;
            serial_out_o <= (mode == `URG_MODE_LOOP || !tbusy_r) ? 1'b1 : tsh_r[0];
            tc_d_r <= !tbusy_r && tx_holding_empty_o;
            if (!tbusy_r && tx_holding_empty_o && !tc_d_r) begin
                line_status_r[`URG_LS_TC] <= 1'b1;
            end
            ms_d_r <= line_status_r[`URG_LS_MS];
            rts_n_o <= !modem_control_r[`URG_MC_RTS];
            dtr_n_o <= !modem_control_r[`URG_MC_DTR];
            // Empty and ready never reach the interrupt
            irq_out_o <= modem_control_r[`URG_MC_IRQ_EN] && (line_status_r[`URG_LS_TC] ||
                (modem_control_r[`URG_MC_MIRQ_EN] && line_status_r[`URG_LS_MS]));
            // Buffered input modelled as half-rate copy of the reference clock
            clock_out_pin_o <= rate_select_r[`URG_RS_CO_SEL] ? clk16 : clk_div_r;
        end
    end
endmodule

// ==== uartrg_consts.vh ====
`ifndef UARTRG_CONSTS_VH
`define UARTRG_CONSTS_VH
// Register select codes {reg_select_hi, reg_select_lo}
`define URG_SEL_DATA 2'h0
`define URG_SEL_LINE 2'h1
`define URG_SEL_MODEM 2'h2
`define URG_SEL_RATE 2'h3
// Line configuration fields
`define URG_LC_LEN_LO 0
`define URG_LC_STOP 2
`define URG_LC_RXPAR_LO 3
`define URG_LC_TXPAR_EN 5
// Parity field codes: 00 none, 01 odd, 10 even
`define URG_PAR_NONE 2'h0
`define URG_PAR_ODD 2'h1
// Rate select fields
`define URG_RS_DIV_LO 0
`define URG_RS_PRE_LO 5
`define URG_RS_CO_SEL 7
// Modem control fields
`define URG_MC_DTR 0
`define URG_MC_RTS 1
`define URG_MC_IRQ_EN 2
`define URG_MC_MODE_LO 3
`define URG_MC_RX_EN 5
`define URG_MC_MIRQ_EN 6
// Operating modes
`define URG_MODE_NORMAL 2'h0
`define URG_MODE_BREAK 2'h1
`define URG_MODE_ECHO 2'h2
`define URG_MODE_LOOP 2'h3
// Line status bits
`define URG_LS_PAR 0
`define URG_LS_FRM 1
`define URG_LS_OVR 2
`define URG_LS_BRK 3
`define URG_LS_MS 4
`define URG_LS_TC 5
`define URG_LS_THE 6
`define URG_LS_RDY 7
`define URG_LS_RESET 8'h60
// Sixteen-times clock ticks per bit, mid-bit tick
`define URG_OVS 5'h10
`define URG_MID 4'h7
`endif

// ==== uartrg_rate_gen.v ====
`timescale 1ns/1ps
`include "uartrg_consts.vh"
module uartrg_rate_gen (
    // Clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    input wire ce_i,
    // Select
    input wire [1:0] pre_sel_i,
    input wire [4:0] div_sel_i,
    // Sixteen-times output
    output reg tick_o,
    output reg clk16_o
);
    // Half-period in thirds of a prescaler period; fractional entries use thirds
    function [10:0] half3;
        input [4:0] s;
        begin
            case (s)
                5'h01: half3 = 11'h003;
                5'h02: half3 = 11'h006;
                5'h03: half3 = 11'h008;
                5'h04: half3 = 11'h00C;
                5'h05: half3 = 11'h010;
                5'h06: half3 = 11'h018;
                5'h07: half3 = 11'h01D;
                5'h08: half3 = 11'h021;
                5'h09: half3 = 11'h030;
                5'h0A: half3 = 11'h060;
                5'h0B: half3 = 11'h0C0;
                5'h0C: half3 = 11'h120;
                5'h0D: half3 = 11'h180;
                5'h0E: half3 = 11'h1B0;
                5'h0F: half3 = 11'h210;
                5'h10: half3 = 11'h300;
                5'h11: half3 = 11'h480;
                default: half3 = 11'h000;
            endcase
        end
    endfunction
    wire [2:0] pre_div = (pre_sel_i == 2'h0) ? 3'h1 : {1'b0, pre_sel_i} + 3'h2;
    reg [2:0] pre_cnt_r;
    reg [11:0] acc_r;
    wire pre_tick = (pre_cnt_r == pre_div - 3'h1);
    wire ext_sel = (half3(div_sel_i) == 11'h000);
    // Fractional divisors dither by thirds, so edges jitter by one prescaler tick
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_cnt_r <= 3'h0;
            acc_r <= 12'h000;
            tick_o <= 1'b0;
            clk16_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            pre_cnt_r <= pre_tick ? 3'h0 : pre_cnt_r + 3'h1;
            if (ext_sel) begin
                // External divisor: prescaler output direct, uneven for 3 and 5
                clk16_o <= (pre_cnt_r < {1'b0, pre_div[2:1]}) || (pre_div == 3'h1 && !clk16_o);
                tick_o <= pre_tick;
            end else if (pre_tick) begin
                if (acc_r + 12'h003 >= {1'b0, half3(div_sel_i)}) begin
                    acc_r <= acc_r + 12'h003 - {1'b0, half3(div_sel_i)};
                    clk16_o <= !clk16_o;
                    tick_o <= clk16_o;
                end else begin
                    acc_r <= acc_r + 12'h003;
                end
            end
        end
    end
endmodule

// ==== uartrg_rx.v ====
`timescale 1ns/1ps
`include "uartrg_consts.vh"
module uartrg_rx (
    // Clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    input wire ce_i,
    // Control
    input wire tick_i,
    input wire en_i,
    input wire [1:0] len_i,
    input wire two_stop_i,
    input wire [1:0] par_i,
    input wire line_i,
    // Character out
    output reg done_o,
    output reg [7:0] data_o,
    output reg par_bit_o,
    output reg par_err_o,
    output reg frm_err_o,
    output reg brk_o
);
    reg [3:0] ph_r;
    reg [3:0] bit_r;
    reg busy_r;
    reg zero_r;
    reg [7:0] sh_r;
    wire [3:0] nd = {2'h0, len_i} + 4'h5;
    wire has_par = (par_i != `URG_PAR_NONE);
    wire [3:0] last = nd + {3'h0, has_par};
    // Only the first stop bit is checked; a second one just idles
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_r <= 4'h0;
            bit_r <= 4'h0;
            busy_r <= 1'b0;
            zero_r <= 1'b0;
            sh_r <= 8'h00;
            done_o <= 1'b0;
            data_o <= 8'h00;
            par_bit_o <= 1'b0;
            par_err_o <= 1'b0;
            frm_err_o <= 1'b0;
            brk_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (!en_i) begin
                busy_r <= 1'b0;
            end else if (tick_i) begin
                if (!busy_r) begin
                    ph_r <= 4'h0;
                    bit_r <= 4'h0;
                    zero_r <= 1'b1;
                    busy_r <= !line_i;
                end else begin
                    ph_r <= ph_r + 4'h1;
                    if (ph_r == `URG_MID) begin
                        ph_r <= `URG_MID - 4'hF + 4'hF - `URG_MID - 4'h8 + 4'h0; // next sample 16 on
                        zero_r <= zero_r & !line_i;
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h0) begin
                            busy_r <= !line_i; // false start
                        end else if (bit_r <= nd) begin
                            sh_r <= {line_i, sh_r[7:1]};
                        end else if (bit_r <= last) begin
                            par_bit_o <= line_i;
                        end else begin
                            busy_r <= 1'b0;
                            done_o <= 1'b1;
                            data_o <= sh_r >> (4'h8 - nd);
                            frm_err_o <= !line_i;
                            par_err_o <= has_par &&
                                ((^(sh_r >> (4'h8 - nd))) ^ par_bit_o ^ (par_i == `URG_PAR_ODD));
                            brk_o <= zero_r & !line_i;
                        end
                    end
                end
            end
        end
    end
    wire unused_stop = two_stop_i;
endmodule

// ==== uartrg_chk_sva.sv ====
`timescale 1ns/1ps
module uartrg_chk (
    // Clock and reset
    input wire ref_clk_i,
    input wire nrst_i,
    input wire ce_i,
    // Processor bus
    input wire chip_select_n_i,
    input wire reg_select_hi_i,
    input wire reg_select_lo_i,
    input wire wr_n_i,
    input wire rd_n_i,
    input wire [7:0] data_i,
    input wire [7:0] data_o,
    input wire data_oe_n_o,
    // Serial and modem pins
    input wire serial_in_i,
    input wire serial_out_o,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire rts_n_o,
    input wire dtr_n_o,
    // Status pins
    input wire tx_holding_empty_o,
    input wire rx_ready_o,
    input wire irq_out_o,
    input wire clock_out_pin_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    wire [1:0] sel = {reg_select_hi_i, reg_select_lo_i};
    wire wr_now = !chip_select_n_i && !wr_n_i;
    wire rd_now = !chip_select_n_i && !rd_n_i;
    reg [7:0] mc_r;
    reg co_sel_r;
    // Shadows follow bus writes, so no check needs to look inside the block
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mc_r <= 8'h00;
            co_sel_r <= 1'b0;
        end else if (wr_now && sel == 2'h2) begin
            mc_r <= data_i;
        end else if (wr_now && sel == 2'h3) begin
            co_sel_r <= data_i[7];
        end
    end
    property p_reset_idle;
        !nrst_i |-> serial_out_o && rts_n_o && dtr_n_o && tx_holding_empty_o && !rx_ready_o
            && !irq_out_o && data_oe_n_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("idle levels wrong in reset");
    property p_irq_mask;
        disable iff (!nrst_i) !mc_r[2] && !$past(mc_r[2]) |-> !irq_out_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt without master enable");
    property p_rts;
        disable iff (!nrst_i) mc_r[1] == $past(mc_r[1]) |-> rts_n_o == !mc_r[1];
    endproperty
    a_rts: assert property (p_rts) else $error("request pin differs from control bit");
    property p_dtr;
        disable iff (!nrst_i) mc_r[0] == $past(mc_r[0]) |-> dtr_n_o == !mc_r[0];
    endproperty
    a_dtr: assert property (p_dtr) else $error("ready pin differs from control bit");
    property p_oe_on;
        disable iff (!nrst_i) rd_now && $past(rd_now) |-> !data_oe_n_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("read data not driven");
    property p_oe_off;
        disable iff (!nrst_i) !data_oe_n_o |-> $past(rd_now);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven without read");
    property p_mc_read;
        disable iff (!nrst_i) rd_now && $past(rd_now) && sel == 2'h2 && $past(sel) == 2'h2
            |-> data_o[6:0] == mc_r[6:0];
    endproperty
    a_mc_read: assert property (p_mc_read) else $error("modem control readback wrong");
    property p_msr;
        disable iff (!nrst_i) (rd_now && sel == 2'h3 && $stable(cts_n_i) && $stable(dsr_n_i))[*5]
            |-> data_o[1:0] == {!dsr_n_i, !cts_n_i};
    endproperty
    a_msr: assert property (p_msr) else $error("modem input image wrong");
    property p_clk_ref;
        disable iff (!nrst_i) !co_sel_r && !$past(co_sel_r) && !$past(co_sel_r, 2)
            && $past(nrst_i) && $past(nrst_i, 2) && ce_i && $past(ce_i)
            |-> clock_out_pin_o != $past(clock_out_pin_o);
    endproperty
    a_clk_ref: assert property (p_clk_ref) else $error("clock out not following input");
    property p_tx_holding_empty;
        disable iff (!nrst_i) $fell(wr_n_i) && !chip_select_n_i && sel == 2'h0
            |-> ##[1:2] !tx_holding_empty_o;
    endproperty
    a_tx_holding_empty: assert property (p_tx_holding_empty) else $error("empty pin kept after write");
endmodule

// ==== uartrg_modem_model.sv ====
`timescale 1ns/1ps
module uartrg_modem_model #(
    parameter integer BIT_NS = 9600
) (
    // Serial line both ways
    input wire line_i,
    output reg line_o,
    // Modem status, active low
    output reg cts_n_o,
    output reg dsr_n_o
);
    reg [7:0] got;
    integer got_cnt;
    integer k;
    initial begin
        line_o = 1'b1;
        cts_n_o = 1'b1;
        dsr_n_o = 1'b1;
        got = 8'h00;
        got_cnt = 0;
    end
    // Start, data LSB first, then the stop level asked
    task send(input [7:0] d, input stop_lvl);
        integer j;
        begin
            line_o = 1'b0;
            #(BIT_NS);
            for (j = 0; j < 8; j = j + 1) begin
                line_o = d[j];
                #(BIT_NS);
            end
            line_o = stop_lvl;
            #(BIT_NS);
            line_o = 1'b1;
            #(2 * BIT_NS);
        end
    endtask
    // Centre sampling; stop level not judged, so break frames count too
    always begin
        @(negedge line_i);
        #(BIT_NS / 2);
        for (k = 0; k < 8; k = k + 1) begin
            #(BIT_NS);
            got[k] = line_i;
        end
        #(BIT_NS);
        got_cnt = got_cnt + 1;
    end
endmodule

// ==== uart_with_rate_generator_tb.sv ====
`timescale 1ns/1ps
module uart_with_rate_generator_tb;
    reg ref_clk_i = 1'b0;
    reg nrst_i = 1'b1;
    reg cs_n = 1'b1;
    reg [1:0] sel = 2'h0;
    reg wr_n = 1'b1;
    reg rd_n = 1'b1;
    reg [7:0] wdat = 8'h00;
    reg [7:0] r;
    reg sdo_low = 1'b0;
    wire [7:0] rdat;
    wire serial_out, serial_in, cts_n, dsr_n, rts_n, dtr_n, tx_holding_empty, rdy, irq, clko, oe_n;
    integer err_count = 0;
    integer samples_checked = 0;
    integer n, t;
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (!serial_out) sdo_low <= 1'b1;
    uartrg_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .chip_select_n_i(cs_n), .reg_select_hi_i(sel[1]), .reg_select_lo_i(sel[0]),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(wdat), .data_o(rdat), .data_oe_n_o(oe_n),
        .serial_in_i(serial_in), .serial_out_o(serial_out), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
        .rts_n_o(rts_n), .dtr_n_o(dtr_n), .tx_holding_empty_o(tx_holding_empty), .rx_ready_o(rdy),
        .irq_out_o(irq), .clock_out_pin_o(clko));
    // One bit is 16 ticks of ref/6: prescaler 3 and divisor 2
    uartrg_modem_model #(.BIT_NS(9600)) peer (.line_i(serial_out), .line_o(serial_in), .cts_n_o(cts_n),
        .dsr_n_o(dsr_n));
    task conclude;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        begin
            @(negedge ref_clk_i);
            cs_n = 1'b0;
            sel = a;
            wdat = d;
            wr_n = 1'b0;
            @(negedge ref_clk_i);
            wr_n = 1'b1;
            cs_n = 1'b1;
        end
    endtask
    // Held five edges so the modem image has passed its synchronisers
    task rd(input [1:0] a, output [7:0] d);
        begin
            @(negedge ref_clk_i);
            cs_n = 1'b0;
            sel = a;
            rd_n = 1'b0;
            repeat (5) @(negedge ref_clk_i);
            d = rdat;
            rd_n = 1'b1;
            cs_n = 1'b1;
        end
    endtask
    task wait_peer(input integer c0);
        begin
            t = 0;
            while (peer.got_cnt == c0 && t < 3000) begin
                @(negedge ref_clk_i);
                t = t + 1;
            end
            if (t >= 3000) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: peer never finished a frame", $time);
            end
        end
    endtask
    task co_count(input [7:0] exp);
        begin
            repeat (3) @(negedge ref_clk_i);
            n = 0;
            r[0] = clko;
            repeat (12) begin
                @(negedge ref_clk_i);
                if (clko !== r[0]) n = n + 1;
                r[0] = clko;
            end
            chk(n[7:0], exp);
        end
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk_i);
        err_count = err_count + 1;
        conclude;
    end
    initial begin
        #10 nrst_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        rd(2'h1, r);
        chk(r, 8'h60);
        rd(2'h2, r);
        chk(r, 8'h00);
        chk({3'h0, rts_n, dtr_n, tx_holding_empty, rdy, serial_out}, 8'h1D);
        rd(2'h1, r);
        chk(r, 8'h00);
        $display("test reset done");
        wr(2'h1, 8'h03);
        wr(2'h3, 8'h21);
        wr(2'h2, 8'h23);
        rd(2'h2, r);
        chk(r, 8'h23);
        chk({6'h0, rts_n, dtr_n}, 8'h00);
        co_count(8'h0C);
        wr(2'h3, 8'hA1);
        co_count(8'h04);
        $display("test config done");
        peer.cts_n_o = 1'b0;
        rd(2'h1, r);
        n = peer.got_cnt;
        wr(2'h0, 8'hA5);
        wait_peer(n);
        chk(peer.got, 8'hA5);
        repeat (200) @(negedge ref_clk_i);
        rd(2'h1, r);
        chk(r & 8'h60, 8'h60);
        $display("test transmit done");
        peer.send(8'h3C, 1'b1);
        rd(2'h0, r);
        chk(r, 8'h3C);
        @(negedge ref_clk_i);
        chk({7'h0, rdy}, 8'h00);
        peer.send(8'h11, 1'b1);
        peer.send(8'h22, 1'b1);
        rd(2'h1, r);
        chk(r & 8'h84, 8'h84);
        rd(2'h0, r);
        chk(r, 8'h11);
        peer.send(8'h55, 1'b0);
        rd(2'h1, r);
        chk(r & 8'h02, 8'h02);
        rd(2'h0, r);
        chk(r, 8'h55);
        peer.send(8'h00, 1'b0);
        rd(2'h1, r);
        chk(r & 8'h08, 8'h08);
        rd(2'h0, r);
        $display("test receive done");
        peer.dsr_n_o = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        chk({7'h0, irq}, 8'h00);
        rd(2'h3, r);
        chk(r & 8'h03, 8'h03);
        rd(2'h1, r);
        chk(r & 8'h10, 8'h10);
        wr(2'h2, 8'h67);
        peer.dsr_n_o = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        chk({7'h0, irq}, 8'h01);
        wr(2'h2, 8'h23);
        repeat (2) @(negedge ref_clk_i);
        chk({7'h0, irq}, 8'h00);
        $display("test modem done");
        peer.cts_n_o = 1'b1;
        n = peer.got_cnt;
        sdo_low = 1'b0;
        wr(2'h0, 8'h77);
        repeat (1500) @(negedge ref_clk_i);
        chk({7'h0, sdo_low}, 8'h00);
        peer.cts_n_o = 1'b0;
        repeat (300) @(negedge ref_clk_i);
        peer.cts_n_o = 1'b1;
        wait_peer(n);
        chk(peer.got, 8'h77);
        peer.cts_n_o = 1'b0;
        wr(2'h2, 8'h3B);
        sdo_low = 1'b0;
        wr(2'h0, 8'h42);
        repeat (1500) @(negedge ref_clk_i);
        chk({7'h0, sdo_low}, 8'h00);
        rd(2'h0, r);
        chk(r, 8'h42);
        n = peer.got_cnt;
        wr(2'h2, 8'h2B);
        wr(2'h0, 8'h42);
        wait_peer(n);
        chk(peer.got, 8'h00);
        n = peer.got_cnt;
        wr(2'h2, 8'h33);
        peer.send(8'h5A, 1'b1);
        wait_peer(n);
        chk(peer.got, 8'h5A);
        $display("test modes done");
        conclude;
    end
endmodule
bind uartrg_top uartrg_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .chip_select_n_i(chip_select_n_i), .reg_select_hi_i(reg_select_hi_i),
    .reg_select_lo_i(reg_select_lo_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .data_i(data_i),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i), .rts_n_o(rts_n_o),
    .dtr_n_o(dtr_n_o), .tx_holding_empty_o(tx_holding_empty_o), .rx_ready_o(rx_ready_o),
    .irq_out_o(irq_out_o), .clock_out_pin_o(clock_out_pin_o));
